// ### rtl/rbc_pkg.sv
// Shared constants and carrier types for the reset and brown-out controller.
package rbc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing.
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PIN_LOW_MIN_PERIODS = 8;
  localparam int unsigned STARTUP_REF_NS = 65_500_000;
  localparam int unsigned STARTUP_REF_MHZ = 4;
  // Start-up delay expressed in oscillator periods at the reference rate.
  localparam int unsigned STARTUP_OSC_PERIODS = STARTUP_REF_NS * STARTUP_REF_MHZ / 1000;
  localparam int unsigned STARTUP_EXTRA_PERIODS = 7;
  localparam int unsigned STARTUP_TOTAL = STARTUP_OSC_PERIODS + STARTUP_EXTRA_PERIODS;
  localparam int unsigned STARTUP_CNT_W = 19;
  localparam int unsigned GLITCH_NS = 32_000;
  // A least time, so it rounds up to whole cycles.
  localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GLITCH_CNT_W = 10;
  localparam int unsigned PIN_CNT_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset vector.
  localparam logic [15:0] VEC_HI_ADDR = 16'hFFFF;
  localparam logic [15:0] VEC_LO_ADDR = 16'hFFFE;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets.
  localparam logic [2:0] ADDR_BO_CTRL = 3'h0;
  localparam logic [2:0] ADDR_SUPPLY_ACT = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_RAM_PAGE = 3'h3;
  localparam logic [2:0] ADDR_CORE_FLAGS = 3'h4;

  // Brown-out control register fields.
  localparam int unsigned BO_EN_BIT = 0;
  localparam int unsigned BO_LVL_LSB = 1;
  localparam int unsigned BO_TRIM_LSB = 4;
  localparam int unsigned BO_FILT_BIT = 6;
  localparam int unsigned BO_DET_DIS_N_BIT = 7;
  // Supply action control register fields.
  localparam int unsigned ACT_SEL_LSB = 0;
  localparam int unsigned ACT_REF_DIS_N_BIT = 2;
  // Status register fields.
  localparam int unsigned ST_BO_BIT = 0;
  localparam int unsigned ST_WDT_BIT = 1;
  localparam int unsigned ST_PIN_BIT = 2;
  localparam int unsigned ST_POR_BIT = 3;
  localparam int unsigned ST_REF_BIT = 4;
  localparam int unsigned ST_FRZ_BIT = 5;
  // Core flags register fields.
  localparam int unsigned CF_DPAGE_BIT = 0;
  localparam int unsigned CF_SUBCLK_BIT = 1;
  localparam int unsigned CF_PCLK_OFF_BIT = 2;

  // Reset values.
  localparam logic [7:0] BO_CTRL_RST = 8'h80;
  localparam logic [7:0] SUPPLY_ACT_RST = 8'h04;
  localparam logic [7:0] RAM_PAGE_RST = 8'h00;
  localparam logic [7:0] CORE_FLAGS_RST = 8'h00;
  localparam logic [3:0] CAUSE_RST = 4'h0;

  // Brown-out action codes.
  localparam logic [1:0] ACT_RESET = 2'b00;
  localparam logic [1:0] ACT_FREEZE = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rbc_bus_req_t;

  typedef struct packed {
    logic enable;
    logic [2:0] level;
    logic [1:0] trim;
    logic self_bias_ref_on;
  } rbc_bo_cfg_t;

  typedef struct packed {
    logic rd;
    logic [15:0] addr;
  } rbc_mem_req_t;

endpackage : rbc_pkg

// ### rtl/rbc_pin_filter.sv
// Reset pin synchroniser and minimum low-width qualifier.
`timescale 1ns/1ns
module rbc_pin_filter (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic pin_level,
  output logic pin_sync,
  output logic pin_reset
);
  import rbc_pkg::*;

  logic meta_q;
  logic sync_q;
  logic [PIN_CNT_W-1:0] low_cnt_q;
  logic [PIN_CNT_W-1:0] low_cnt_d;

  ////////////////////////////////////////////////////////////////////////////
  // Two flops; only the second one is looked at.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= pin_level;
      sync_q <= meta_q;
    end
  end

  // Saturating count of consecutive low cycles on the synchronised pin.
  always_comb begin
    low_cnt_d = '0;
    if (!sync_q) begin
      low_cnt_d = (low_cnt_q == PIN_CNT_W'(PIN_LOW_MIN_PERIODS)) ? low_cnt_q : low_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      low_cnt_q <= '0;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end

  // Shorter pulses never reach the core; the reset holds while the pin stays low.
  assign pin_reset = !sync_q && (low_cnt_q >= PIN_CNT_W'(PIN_LOW_MIN_PERIODS - 1));
  assign pin_sync = sync_q;

endmodule : rbc_pin_filter

// ### rtl/rbc_bo_filter.sv
// Brown-out low-detect glitch filter.
`timescale 1ns/1ns
module rbc_bo_filter (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic raw_low,
  input wire logic filter_on,
  output logic qualified
);
  import rbc_pkg::*;

  logic [GLITCH_CNT_W-1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // Count how long the detector has reported low, saturating at the window.
  always_ff @(posedge ref_clk) begin
    if (srst || !raw_low) begin
      cnt_q <= '0;
    end else if (cnt_q != GLITCH_CNT_W'(GLITCH_CYC)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // With the filter off a detection passes at once.
  assign qualified = raw_low && (!filter_on || cnt_q == GLITCH_CNT_W'(GLITCH_CYC));

endmodule : rbc_bo_filter

// ### rtl/rbc_reset_ctrl.sv
// Reset generation, start-up sequencing and brown-out response.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ns

// Contract
// - Four sources assert internal reset
// - Reset clears page pointer, flag, clock mode
// - Start-up delay plus seven periods
// - Pin high releases reset, start-up follows
// - Program counter loaded from top vector
// - Reset leaves user RAM untouched
// - Power-on reset holds until supply good
// - Both options set make pin a port
// - Power-on option alone keeps pin reset
// - Control register enables brown-out detector
// - Eight levels, each with two-bit trim
// - Filter ignores lows under 32us
// - Action 00 gives a device reset
// - Action 10 freezes until supply recovers
// - Brown-out sets a sticky cause flag
// - Self-bias reference needs both disables low
// - Start-up interval halts all operations
module rbc_reset_ctrl #(
  parameter int unsigned STARTUP_CYCLES = rbc_pkg::STARTUP_TOTAL
) (
  input wire logic ref_clk,
  input wire logic srst,
  input rbc_pkg::rbc_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic reset_pin_level,
  input wire logic cfg_por_option,
  input wire logic reset_pin_reuse_option,
  input wire logic por_supply_low,
  input wire logic brownout_detector_low,
  input wire logic watchdog_reset,
  output rbc_pkg::rbc_bo_cfg_t bo_cfg,
  output logic shared_reset_port_pin,
  output rbc_pkg::rbc_mem_req_t vec_req,
  input wire logic [7:0] vec_rdata,
  output logic [15:0] pc_value,
  output logic pc_load,
  output logic core_reset,
  output logic core_halt,
  output logic cpu_freeze,
  output logic [7:0] ram_page_pointer,
  output logic direct_page_select,
  output logic sub_clock_select,
  output logic periph_clock_en
);
  import rbc_pkg::*;

  typedef enum logic [2:0] {
    ST_HOLD = 3'b000,
    ST_START = 3'b001,
    ST_FETCH_HI = 3'b010,
    ST_FETCH_LO = 3'b011,
    ST_LOAD = 3'b100,
    ST_RUN = 3'b101
  } rbc_state_t;

  // True when a bus request targets the given register.
  function automatic logic rbc_hit(input rbc_bus_req_t req, input logic [2:0] off);
    rbc_hit = (req.addr == off);
  endfunction : rbc_hit

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  rbc_state_t state_q;
  rbc_state_t state_d;
  logic [STARTUP_CNT_W-1:0] start_cnt_q;
  logic [7:0] bo_ctrl_q;
  logic [7:0] supply_act_q;
  logic [7:0] ram_page_q;
  logic [7:0] core_flags_q;
  logic [3:0] cause_q;
  logic [3:0] cause_set;
  logic freeze_q;
  logic port_pin_q;
  logic [7:0] vec_hi_q;
  logic [15:0] pc_q;
  logic pc_load_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic pin_sync;
  logic pin_reset_raw;
  logic pin_is_port;
  logic pin_reset;
  logic bo_enabled;
  logic bo_qualified;
  logic bo_event;
  logic bo_reset;
  logic bo_freeze_req;
  logic self_bias_on;
  logic reset_any;
  logic core_rst;
  logic power_rst;
  logic wr_bo_ctrl;
  logic wr_supply_act;
  logic wr_status;
  logic wr_ram_page;
  logic wr_core_flags;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin: synchronised and width-qualified before it can reset anything.
  rbc_pin_filter u_pin_filter (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin_level(reset_pin_level),
    .pin_sync(pin_sync),
    .pin_reset(pin_reset_raw)
  );

  // The pin becomes a port only when both options are set; otherwise it resets.
  assign pin_is_port = cfg_por_option && reset_pin_reuse_option;
  assign pin_reset = pin_reset_raw && !pin_is_port;

  // Port view of the shared pin, registered so the output is a flop.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      port_pin_q <= 1'b1;
    end else begin
      port_pin_q <= pin_is_port ? pin_sync : 1'b1;
    end
  end

  assign shared_reset_port_pin = port_pin_q;

  ////////////////////////////////////////////////////////////////////////////
  // Brown-out detection path.
  rbc_bo_filter u_bo_filter (
    .ref_clk(ref_clk),
    .srst(srst),
    .raw_low(brownout_detector_low),
    .filter_on(bo_ctrl_q[BO_FILT_BIT]),
    .qualified(bo_qualified)
  );

  // Detections only count while the control register enables the detector.
  assign bo_enabled = bo_ctrl_q[BO_EN_BIT];
  assign bo_event = bo_enabled && bo_qualified;
  assign bo_reset = bo_event && (supply_act_q[ACT_SEL_LSB +: 2] == ACT_RESET);
  assign bo_freeze_req = bo_event && (supply_act_q[ACT_SEL_LSB +: 2] == ACT_FREEZE);

  // Self-bias reference: both active-low disables must be cleared.
  assign self_bias_on = !supply_act_q[ACT_REF_DIS_N_BIT] && !bo_ctrl_q[BO_DET_DIS_N_BIT];

  // Level and trim go straight to the analog comparator.
  always_comb begin
    bo_cfg.enable = bo_enabled;
    bo_cfg.level = bo_ctrl_q[BO_LVL_LSB +: 3];
    bo_cfg.trim = bo_ctrl_q[BO_TRIM_LSB +: 2];
    bo_cfg.self_bias_ref_on = self_bias_on;
  end

  // Freeze ends on the raw detector, so recovery is seen without filter delay.
  always_ff @(posedge ref_clk) begin
    if (power_rst) begin
      freeze_q <= 1'b0;
    end else if (bo_freeze_req) begin
      freeze_q <= 1'b1;
    end else if (!brownout_detector_low) begin
      freeze_q <= 1'b0;
    end
  end

  assign cpu_freeze = freeze_q;

  ////////////////////////////////////////////////////////////////////////////
  // Reset combining. The watchdog pulse only needs one cycle in HOLD.
  assign reset_any = srst || por_supply_low || pin_reset || bo_reset || watchdog_reset;
  assign power_rst = srst || por_supply_low;

  // Sequencer next state.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_HOLD: begin
        if (!reset_any) begin
          state_d = ST_START;
        end
      end
      ST_START: begin
        if (start_cnt_q == STARTUP_CNT_W'(STARTUP_CYCLES - 1)) begin
          state_d = ST_FETCH_HI;
        end
      end
      ST_FETCH_HI: begin
        state_d = ST_FETCH_LO;
      end
      ST_FETCH_LO: begin
        state_d = ST_LOAD;
      end
      ST_LOAD: begin
        state_d = ST_RUN;
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_HOLD;
      end
    endcase
    if (reset_any) begin
      state_d = ST_HOLD;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= ST_HOLD;
    end else begin
      state_q <= state_d;
    end
  end

  // Start-up counter runs only in START and restarts on every new reset.
  always_ff @(posedge ref_clk) begin
    if (srst || state_q != ST_START) begin
      start_cnt_q <= '0;
    end else begin
      start_cnt_q <= start_cnt_q + 1'b1;
    end
  end

  // Core stays in reset through HOLD and START; everything is halted until RUN.
  assign core_rst = (state_q == ST_HOLD);
  assign core_reset = (state_q == ST_HOLD) || (state_q == ST_START);
  assign core_halt = (state_q != ST_RUN) || freeze_q;

  ////////////////////////////////////////////////////////////////////////////
  // Vector fetch: high byte first, then low byte, each answered a cycle later.
  always_comb begin
    vec_req.rd = (state_q == ST_FETCH_HI) || (state_q == ST_FETCH_LO);
    vec_req.addr = (state_q == ST_FETCH_LO) ? VEC_LO_ADDR : VEC_HI_ADDR;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      vec_hi_q <= 8'h00;
    end else if (state_q == ST_FETCH_LO) begin
      vec_hi_q <= vec_rdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pc_q <= 16'h0000;
      pc_load_q <= 1'b0;
    end else begin
      pc_load_q <= (state_q == ST_LOAD);
      if (state_q == ST_LOAD) begin
        pc_q <= {vec_hi_q, vec_rdata};
      end
    end
  end

  assign pc_value = pc_q;
  assign pc_load = pc_load_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  assign wr_bo_ctrl = bus_req.wr && rbc_hit(bus_req, ADDR_BO_CTRL);
  assign wr_supply_act = bus_req.wr && rbc_hit(bus_req, ADDR_SUPPLY_ACT);
  assign wr_status = bus_req.wr && rbc_hit(bus_req, ADDR_STATUS);
  assign wr_ram_page = bus_req.wr && rbc_hit(bus_req, ADDR_RAM_PAGE);
  assign wr_core_flags = bus_req.wr && rbc_hit(bus_req, ADDR_CORE_FLAGS);

  // Control registers are redefined by every reset; user RAM is not in this block.
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      bo_ctrl_q <= BO_CTRL_RST;
    end else if (wr_bo_ctrl) begin
      bo_ctrl_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      supply_act_q <= SUPPLY_ACT_RST;
    end else if (wr_supply_act) begin
      supply_act_q <= bus_req.wdata;
    end
  end

  // Core state cleared on every reset source.
  always_ff @(posedge ref_clk) begin
    if (core_rst) begin
      ram_page_q <= RAM_PAGE_RST;
      core_flags_q <= CORE_FLAGS_RST;
    end else begin
      if (wr_ram_page) begin
        ram_page_q <= bus_req.wdata;
      end
      if (wr_core_flags) begin
        core_flags_q <= bus_req.wdata;
      end
    end
  end

  assign ram_page_pointer = ram_page_q;
  assign direct_page_select = core_flags_q[CF_DPAGE_BIT];
  assign sub_clock_select = core_flags_q[CF_SUBCLK_BIT];
  assign periph_clock_en = !core_flags_q[CF_PCLK_OFF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Cause flags survive the reset they report; of the resets only srst clears them, not por_supply_low.
  always_comb begin
    cause_set = '0;
    cause_set[ST_BO_BIT] = bo_event;
    cause_set[ST_WDT_BIT] = watchdog_reset;
    cause_set[ST_PIN_BIT] = pin_reset;
    cause_set[ST_POR_BIT] = por_supply_low;
  end

  // Write one to clear; a set in the same cycle wins.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cause_q <= CAUSE_RST;
    end else if (wr_status) begin
      cause_q <= (cause_q & ~bus_req.wdata[3:0]) | cause_set;
    end else begin
      cause_q <= cause_q | cause_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data stand in the cycle after the strobe; unmapped reads return zero.
  always_comb begin
    rdata_d = 8'h00;
    unique case (bus_req.addr)
      ADDR_BO_CTRL: rdata_d = bo_ctrl_q;
      ADDR_SUPPLY_ACT: rdata_d = supply_act_q;
      ADDR_STATUS: begin
        rdata_d[3:0] = cause_q;
        rdata_d[ST_REF_BIT] = self_bias_on;
        rdata_d[ST_FRZ_BIT] = freeze_q;
      end
      ADDR_RAM_PAGE: rdata_d = ram_page_q;
      ADDR_CORE_FLAGS: rdata_d = core_flags_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (bus_req.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign bus_rdata = rdata_q;

endmodule : rbc_reset_ctrl

// ### sim/rbc_pin_driver.sv
// Behavioural model of the external reset circuit on the reset pin.
`timescale 1ns/1ns
module rbc_pin_driver (
  input wire logic ref_clk,
  output logic pin_level
);
  // The pull-up holds the pin high whenever the circuit is idle.
  initial pin_level = 1'b1;

  // Pull the pin low for n sampling edges, then release it to the pull-up.
  task automatic pulse_low(input int n);
    @(posedge ref_clk);
    pin_level <= 1'b0;
    repeat (n) @(posedge ref_clk);
    pin_level <= 1'b1;
  endtask : pulse_low
endmodule : rbc_pin_driver

// ### sim/rbc_reset_ctrl_properties.sv
// Port-level properties of the reset and brown-out controller.
`timescale 1ns/1ns
module rbc_reset_ctrl_properties #(
  parameter int unsigned STARTUP_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic reset_pin_level,
  input wire logic cfg_por_option,
  input wire logic reset_pin_reuse_option,
  input wire logic por_supply_low,
  input wire logic brownout_detector_low,
  input wire logic watchdog_reset,
  input rbc_pkg::rbc_bo_cfg_t bo_cfg,
  input wire logic shared_reset_port_pin,
  input rbc_pkg::rbc_mem_req_t vec_req,
  input wire logic [7:0] vec_rdata,
  input wire logic [15:0] pc_value,
  input wire logic pc_load,
  input wire logic core_reset,
  input wire logic core_halt,
  input wire logic cpu_freeze,
  input wire logic [7:0] ram_page_pointer,
  input wire logic direct_page_select,
  input wire logic sub_clock_select,
  input wire logic periph_clock_en
);
  import rbc_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic both_opt;
  int unsigned hold_cnt_q;
  assign both_opt = cfg_por_option && reset_pin_reuse_option;

  // Length of the current core reset run; a counter keeps the start-up bound cheap.
  always_ff @(posedge ref_clk) begin
    hold_cnt_q <= (srst || !core_reset) ? 0 : hold_cnt_q + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_startup_len: assert property ($fell(core_reset) |-> hold_cnt_q >= STARTUP_CYCLES + 1)
    else $error("start-up too short");
  chk_vec_order: assert property (vec_req.rd && vec_req.addr == VEC_HI_ADDR |=>
    vec_req.rd && vec_req.addr == VEC_LO_ADDR) else $error("vector order");
  chk_vec_load: assert property (vec_req.rd && vec_req.addr == VEC_HI_ADDR |-> ##3 pc_load &&
    pc_value == {$past(vec_rdata, 2), $past(vec_rdata)}) else $error("vector load");
  chk_wdt_reset: assert property (watchdog_reset |-> ##[1:2] core_reset)
    else $error("watchdog reset lost");
  chk_por_hold: assert property (por_supply_low |-> ##[1:2] core_reset)
    else $error("supply low without reset");
  chk_pin_qualify: assert property ((!reset_pin_level && !both_opt) [*8] |-> ##[1:8] core_reset)
    else $error("pin reset lost");
  chk_port_follow: assert property (both_opt [*4] |-> shared_reset_port_pin == $past(reset_pin_level, 3))
    else $error("port pin level");
  chk_pin_mode: assert property (!both_opt |=> shared_reset_port_pin)
    else $error("port pin while reset");
  chk_halt_start: assert property (core_reset |-> core_halt)
    else $error("core runs in reset");
  chk_clear_core: assert property ($rose(core_reset) |=> ram_page_pointer == 8'h00 &&
    !direct_page_select && !sub_clock_select && periph_clock_en) else $error("core state kept");
  chk_freeze_release: assert property (cpu_freeze && !brownout_detector_low |=> !cpu_freeze)
    else $error("freeze held");
  chk_freeze_halt: assert property (cpu_freeze |-> core_halt)
    else $error("frozen core runs");
  chk_freeze_cause: assert property ($rose(cpu_freeze) |-> $past(bo_cfg.enable) &&
    $past(brownout_detector_low)) else $error("freeze without cause");

  // Main scenarios.
  cov_boot: cover property ($rose(pc_load));
  cov_freeze: cover property ($rose(cpu_freeze));
  cov_port: cover property (both_opt && !reset_pin_level);
endmodule : rbc_reset_ctrl_properties

bind rbc_reset_ctrl rbc_reset_ctrl_properties #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_rbc_reset_ctrl_properties (
  .ref_clk(ref_clk), .srst(srst), .reset_pin_level(reset_pin_level), .cfg_por_option(cfg_por_option),
  .reset_pin_reuse_option(reset_pin_reuse_option), .por_supply_low(por_supply_low),
  .brownout_detector_low(brownout_detector_low), .watchdog_reset(watchdog_reset), .bo_cfg(bo_cfg),
  .shared_reset_port_pin(shared_reset_port_pin), .vec_req(vec_req), .vec_rdata(vec_rdata),
  .pc_value(pc_value), .pc_load(pc_load), .core_reset(core_reset), .core_halt(core_halt),
  .cpu_freeze(cpu_freeze), .ram_page_pointer(ram_page_pointer), .direct_page_select(direct_page_select),
  .sub_clock_select(sub_clock_select), .periph_clock_en(periph_clock_en)
);

// ### sim/rbc_reset_ctrl_test.sv
// Self-checking bench for the reset and brown-out controller.
`timescale 1ns/1ns
module rbc_reset_ctrl_test;
  import rbc_pkg::*;
  localparam int unsigned START_N = 20;
  localparam logic [15:0] VEC = 16'hA53C;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  rbc_bus_req_t bus_req = '0;
  logic cfg_por_option = 1'b1;
  logic reset_pin_reuse_option = 1'b0;
  logic por_supply_low = 1'b0;
  logic brownout_detector_low = 1'b0;
  logic watchdog_reset = 1'b0;
  logic [7:0] vec_rdata = 8'h00;
  logic reset_pin_level, shared_reset_port_pin, pc_load, core_reset, core_halt, cpu_freeze;
  logic direct_page_select, sub_clock_select, periph_clock_en, seen_frz, seen_rst;
  logic [7:0] bus_rdata, ram_page_pointer, d;
  logic [15:0] pc_value;
  rbc_bo_cfg_t bo_cfg;
  rbc_mem_req_t vec_req;
  int errors = 0;
  int n_compared = 0;

  // Half-period toggle; the short start-up keeps the run brief.
  always #25 ref_clk = ~ref_clk;

  // The vector store answers one cycle after each read.
  always @(posedge ref_clk) begin
    vec_rdata <= (vec_req.addr == VEC_HI_ADDR) ? VEC[15:8] : VEC[7:0];
  end

  rbc_reset_ctrl #(.STARTUP_CYCLES(START_N)) i_rbc_reset_ctrl (
    .ref_clk(ref_clk), .srst(srst), .bus_req(bus_req), .bus_rdata(bus_rdata), .reset_pin_level(reset_pin_level),
    .cfg_por_option(cfg_por_option), .reset_pin_reuse_option(reset_pin_reuse_option),
    .por_supply_low(por_supply_low), .brownout_detector_low(brownout_detector_low),
    .watchdog_reset(watchdog_reset), .bo_cfg(bo_cfg), .shared_reset_port_pin(shared_reset_port_pin),
    .vec_req(vec_req), .vec_rdata(vec_rdata), .pc_value(pc_value), .pc_load(pc_load), .core_reset(core_reset),
    .core_halt(core_halt), .cpu_freeze(cpu_freeze), .ram_page_pointer(ram_page_pointer),
    .direct_page_select(direct_page_select), .sub_clock_select(sub_clock_select),
    .periph_clock_en(periph_clock_en)
  );
  rbc_pin_driver i_rbc_pin_driver (.ref_clk(ref_clk), .pin_level(reset_pin_level));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd(input logic [2:0] a);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    @(negedge ref_clk);
    d = bus_rdata;
  endtask : rd

  // Counts reset and fetch cycles up to the program counter load.
  task automatic boot_chk(input int exp_hi);
    int nh;
    int nl;
    nh = 0;
    nl = 0;
    repeat (400) begin
      @(negedge ref_clk);
      if (pc_load === 1'b1) break;
      if (core_reset === 1'b1) nh++;
      else if (nh > 0) nl++;
    end
    chk(pc_value, VEC);
    chk(16'(nl), 16'h0003);
    if (exp_hi > 0) chk(16'(nh), 16'(exp_hi));
  endtask : boot_chk

  // Holds the detector output low-supply for n cycles, noting any reaction.
  task automatic bo_low(input int n);
    seen_frz = 1'b0;
    seen_rst = 1'b0;
    @(posedge ref_clk);
    brownout_detector_low <= 1'b1;
    repeat (n) begin
      @(negedge ref_clk);
      seen_frz |= (cpu_freeze === 1'b1);
      seen_rst |= (core_reset === 1'b1);
    end
    @(posedge ref_clk);
    brownout_detector_low <= 1'b0;
  endtask : bo_low

  task automatic wdt_pulse();
    @(posedge ref_clk);
    watchdog_reset <= 1'b1;
    @(posedge ref_clk);
    watchdog_reset <= 1'b0;
  endtask : wdt_pulse

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(ADDR_BO_CTRL);
    chk(16'(d), 16'(BO_CTRL_RST));
    rd(ADDR_SUPPLY_ACT);
    chk(16'(d), 16'(SUPPLY_ACT_RST));
    wr(3'h5, 8'hFF);
    rd(3'h5);
    chk(16'(d), 16'h0000);
    wr(ADDR_RAM_PAGE, 8'h5A);
    wr(ADDR_CORE_FLAGS, 8'h07);
    @(negedge ref_clk);
    chk(16'({ram_page_pointer, direct_page_select, sub_clock_select, periph_clock_en}), 16'h02D6);
    wdt_pulse();
    boot_chk(START_N + 1);
    chk(16'({ram_page_pointer, direct_page_select, sub_clock_select, periph_clock_en}), 16'h0001);
    rd(ADDR_STATUS);
    chk(16'(d[ST_WDT_BIT]), 16'h0001);
  endtask : t_regs

  task automatic t_pin();
    i_rbc_pin_driver.pulse_low(7);
    cyc(12);
    @(negedge ref_clk);
    chk(16'(core_reset), 16'h0000);
    i_rbc_pin_driver.pulse_low(8);
    boot_chk(0);
    rd(ADDR_STATUS);
    chk(16'(d[ST_PIN_BIT]), 16'h0001);
  endtask : t_pin

  // With both options set the pin is a plain input and never resets.
  task automatic t_port();
    @(posedge ref_clk);
    reset_pin_reuse_option <= 1'b1;
    fork
      i_rbc_pin_driver.pulse_low(20);
      begin
        cyc(10);
        @(negedge ref_clk);
        chk(16'({shared_reset_port_pin, core_reset}), 16'h0000);
      end
    join
    cyc(12);
    @(negedge ref_clk);
    chk(16'({shared_reset_port_pin, core_reset}), 16'h0002);
    @(posedge ref_clk);
    reset_pin_reuse_option <= 1'b0;
  endtask : t_port

  task automatic t_por();
    @(posedge ref_clk);
    por_supply_low <= 1'b1;
    cyc(30);
    @(negedge ref_clk);
    chk(16'({core_reset, core_halt}), 16'h0003);
    @(posedge ref_clk);
    por_supply_low <= 1'b0;
    boot_chk(START_N + 1);
    rd(ADDR_STATUS);
    chk(16'(d[ST_POR_BIT]), 16'h0001);
  endtask : t_por

  task automatic t_levels();
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_BO_CTRL, {2'b10, 2'(i), 3'(i), 1'b0});
      @(negedge ref_clk);
      chk(16'({bo_cfg.level, bo_cfg.trim}), 16'({3'(i), 2'(i)}));
    end
    wr(ADDR_SUPPLY_ACT, 8'h00);
    wr(ADDR_BO_CTRL, 8'h00);
    @(negedge ref_clk);
    chk(16'(bo_cfg.self_bias_ref_on), 16'h0001);
    wr(ADDR_BO_CTRL, 8'h80);
    rd(ADDR_STATUS);
    chk(16'({bo_cfg.self_bias_ref_on, d[ST_REF_BIT]}), 16'h0000);
    bo_low(10);
    chk(16'({seen_rst, seen_frz}), 16'h0000);
  endtask : t_levels

  task automatic t_bo();
    wr(ADDR_BO_CTRL, 8'h81);
    bo_low(3);
    chk(16'({seen_rst, seen_frz}), 16'h0002);
    boot_chk(0);
    chk(16'(bo_cfg.enable), 16'h0000);
    rd(ADDR_STATUS);
    chk(16'(d[ST_BO_BIT]), 16'h0001);
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS);
    chk(16'(d[ST_BO_BIT]), 16'h0000);
    wr(ADDR_SUPPLY_ACT, 8'h06);
    wr(ADDR_BO_CTRL, 8'hC1);
    bo_low(int'(GLITCH_CYC) - 40);
    chk(16'({seen_rst, seen_frz}), 16'h0000);
    bo_low(int'(GLITCH_CYC) + 40);
    chk(16'({seen_rst, seen_frz}), 16'h0001);
    cyc(1);
    @(negedge ref_clk);
    chk(16'(cpu_freeze), 16'h0000);
    wr(ADDR_STATUS, 8'h01);
    wr(ADDR_SUPPLY_ACT, 8'h05);
    wr(ADDR_BO_CTRL, 8'h81);
    bo_low(4);
    rd(ADDR_STATUS);
    chk(16'({seen_rst, seen_frz, d[ST_BO_BIT]}), 16'h0001);
  endtask : t_bo

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Main sequence after sixteen cycles of reset.
  initial begin
    cyc(16);
    srst <= 1'b0;
    boot_chk(0);
    t_regs();
    t_pin();
    t_port();
    t_por();
    t_levels();
    t_bo();
    end_of_test();
  end

  // The scenarios need well under ten thousand cycles.
  initial begin
    cyc(20000);
    errors++;
    end_of_test();
  end
endmodule : rbc_reset_ctrl_test
